// File: verilog/awp_player.sv
// How it works
// - marker byte bits 0..3 enable markers 1..4
// - byte 0f lights all four markers
// - byte 00 keeps every marker off
// - marker bits 4..7 are ignored
// - each active bit drives its own marker output
// - I/Q load without markers zeroes marker store
// - marker load leaves stored I/Q untouched
// - I/Q load clears markers and marks the header unspecified
// - I/Q data is interleaved signed 16-bit pairs
// - sample is two I, two Q, one marker byte
// - fewer than 60 samples is never playable
// - selecting a waveform first loads its header settings
// - samples are produced only while playback is enabled
// - store commits I/Q, markers and header together
`timescale 1ns/1ps
`default_nettype none
`include "awp_params.svh"

module awp_player
  import awp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic dlStart,
  input wire logic dlKind,
  input wire logic dlValid,
  input wire logic [7:0] dlByte,
  input wire logic dlEnd,
  input wire logic hdrLoad,
  input wire logic [`AWP_HDR_W-1:0] hdrWord,
  input wire logic storeReq,
  input wire logic selectReq,
  input wire logic stopReq,
  input wire logic arbOn,
  output logic dlBusy,
  output logic dlError,
  output logic pending,
  output logic playable,
  output logic [`AWP_CW-1:0] waveLen,
  output logic [`AWP_HDR_W-1:0] playSettings,
  output logic playSettingsValid,
  output logic playing,
  output logic sampleValid,
  output logic signed [15:0] sampleI,
  output logic signed [15:0] sampleQ,
  output logic [3:0] markerOut
);

  // two banks per part: downloads fill the idle bank, store flips banks
  logic [31:0] iqMem [0:1][0:`AWP_DEPTH-1];
  logic [3:0] mkrMem [0:1][0:`AWP_DEPTH-1];
  logic [`AWP_HDR_W-1:0] hdrMem [0:1];
  logic hdrSpec [0:1];
  logic [`AWP_CW-1:0] iqLen [0:1];

  logic iqBank;
  logic mkrBank;
  logic hdrBank;
  logic iqPend;
  logic mkrPend;
  logic hdrPend;

  logic loading;
  logic curKind;
  logic [1:0] bytePos;
  logic [23:0] iqAcc;
  logic [`AWP_CW-1:0] ptCnt;

  awp_state_t state;
  logic [`AWP_AW-1:0] rdAddr;
  logic running;
  logic commit;
  logic iqPointDone;
  logic mkrPointDone;
  logic roomLeft;

  assign roomLeft = ptCnt < `AWP_DEPTH_CNT;
  assign iqPointDone = loading && dlValid && curKind == `AWP_KIND_IQ && bytePos == `AWP_BYTE_LAST;
  assign mkrPointDone = loading && dlValid && curKind == `AWP_KIND_MKR;
  // store is held off while a file is still arriving
  assign commit = storeReq && !loading;
  assign waveLen = iqLen[iqBank];
  assign playable = iqLen[iqBank] >= `AWP_MIN_SAMPLES;
  assign pending = iqPend || mkrPend || hdrPend;
  assign dlBusy = loading;
  assign playing = state == AWP_ST_PLAY;
  assign running = state == AWP_ST_PLAY && arbOn && playable;

  // download framing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      loading <= 1'b0;
      curKind <= `AWP_KIND_IQ;
    end
    else if (ce)
    begin
      if (dlStart)
      begin
        loading <= 1'b1;
        curKind <= dlKind;
      end
      else if (dlEnd)
      begin
        loading <= 1'b0;
      end
    end
  end

  // byte assembly and point counting
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bytePos <= `AWP_BYTE_FIRST;
      iqAcc <= 24'h000000;
      ptCnt <= `AWP_CNT_ZERO;
    end
    else if (ce)
    begin
      if (dlStart)
      begin
        bytePos <= `AWP_BYTE_FIRST;
        ptCnt <= `AWP_CNT_ZERO;
      end
      else if (loading && dlValid)
      begin
        if (curKind == `AWP_KIND_IQ)
        begin
          // I high, I low, Q high, Q low
          iqAcc <= {iqAcc[15:0], dlByte};
          bytePos <= bytePos + `AWP_BYTE_STEP;
        end
        if ((iqPointDone || mkrPointDone) && roomLeft)
        begin
          ptCnt <= ptCnt + `AWP_CNT_ONE;
        end
      end
    end
  end

  // download error: short I/Q file, overflow, odd byte tail, or store while loading
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dlError <= 1'b0;
    end
    else if (ce)
    begin
      // a new file clears the flag, but a set in the same edge wins
      if (dlStart)
      begin
        dlError <= 1'b0;
      end
      if ((iqPointDone || mkrPointDone) && !roomLeft)
      begin
        dlError <= 1'b1;
      end
      if (loading && dlEnd && curKind == `AWP_KIND_IQ && (ptCnt < `AWP_MIN_SAMPLES || bytePos != `AWP_BYTE_FIRST))
      begin
        dlError <= 1'b1;
      end
      // refused store must flag even when the file closes in that edge
      if (storeReq && loading)
      begin
        dlError <= 1'b1;
      end
    end
  end

  // waveform storage; no reset on the arrays themselves
  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (iqPointDone && roomLeft)
      begin
        iqMem[~iqBank][ptCnt[`AWP_AW-1:0]] <= {iqAcc, dlByte};
        // a fresh I/Q file brings an all-zero marker file with it
        mkrMem[~mkrBank][ptCnt[`AWP_AW-1:0]] <= `AWP_MKR_OFF;
      end
      else if (mkrPointDone && roomLeft)
      begin
        // only the marker bank is touched here
        mkrMem[~mkrBank][ptCnt[`AWP_AW-1:0]] <= dlByte[`AWP_MKR_MSB:`AWP_MKR_LSB];
      end
    end
  end

  // pending header and pending length
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int b = 0; b < 2; b++)
      begin
        hdrMem[b] <= `AWP_HDR_RST;
        hdrSpec[b] <= 1'b0;
        iqLen[b] <= `AWP_CNT_ZERO;
      end
    end
    else if (ce)
    begin
      if (dlStart && dlKind == `AWP_KIND_IQ)
      begin
        hdrSpec[~hdrBank] <= 1'b0;
      end
      else if (hdrLoad)
      begin
        hdrMem[~hdrBank] <= hdrWord;
        hdrSpec[~hdrBank] <= 1'b1;
      end
      if (loading && dlEnd && curKind == `AWP_KIND_IQ)
      begin
        // short file is kept as length zero, so it never plays
        iqLen[~iqBank] <= (ptCnt < `AWP_MIN_SAMPLES) ? `AWP_CNT_ZERO : ptCnt;
      end
    end
  end

  // pending flags and the joint bank flip
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      iqBank <= 1'b0;
      mkrBank <= 1'b0;
      hdrBank <= 1'b0;
      iqPend <= 1'b0;
      mkrPend <= 1'b0;
      hdrPend <= 1'b0;
    end
    else if (ce)
    begin
      if (commit)
      begin
        // every part with a pending flag moves in the same edge
        iqBank <= iqBank ^ iqPend;
        mkrBank <= mkrBank ^ mkrPend;
        hdrBank <= hdrBank ^ hdrPend;
        iqPend <= 1'b0;
        mkrPend <= 1'b0;
        hdrPend <= 1'b0;
      end
      else
      begin
        if (dlStart && dlKind == `AWP_KIND_IQ)
        begin
          iqPend <= 1'b1;
          mkrPend <= 1'b1;
          hdrPend <= 1'b1;
        end
        else if (dlStart)
        begin
          mkrPend <= 1'b1;
        end
        if (hdrLoad)
        begin
          hdrPend <= 1'b1;
        end
      end
    end
  end

  // playback sequencing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= AWP_ST_IDLE;
    end
    else if (ce)
    begin
      case (state)
        AWP_ST_IDLE:
        begin
          if (selectReq)
          begin
            state <= AWP_ST_HDR;
          end
        end
        AWP_ST_HDR:
        begin
          state <= AWP_ST_PLAY;
        end
        AWP_ST_PLAY:
        begin
          if (stopReq)
          begin
            state <= AWP_ST_IDLE;
          end
          else if (selectReq)
          begin
            state <= AWP_ST_HDR;
          end
        end
        default:
        begin
          state <= AWP_ST_IDLE;
        end
      endcase
    end
  end

  // header settings; unspecified keeps what the previous waveform left
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      playSettings <= `AWP_HDR_RST;
      playSettingsValid <= 1'b0;
    end
    else if (ce)
    begin
      if (state == AWP_ST_HDR)
      begin
        playSettingsValid <= hdrSpec[hdrBank];
        if (hdrSpec[hdrBank])
        begin
          playSettings <= hdrMem[hdrBank];
        end
      end
    end
  end

  // read address, wrapping straight from the last point to the first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdAddr <= `AWP_ADDR_ZERO;
    end
    else if (ce)
    begin
      if (state == AWP_ST_HDR || commit)
      begin
        rdAddr <= `AWP_ADDR_ZERO;
      end
      else if (running)
      begin
        if ({1'b0, rdAddr} == iqLen[iqBank] - `AWP_CNT_ONE)
        begin
          rdAddr <= `AWP_ADDR_ZERO;
        end
        else
        begin
          rdAddr <= rdAddr + `AWP_ADDR_ONE;
        end
      end
    end
  end

  // sample output stage, one point per enabled cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sampleValid <= 1'b0;
      sampleI <= `AWP_HALF_RST;
      sampleQ <= `AWP_HALF_RST;
      markerOut <= `AWP_MKR_OFF;
    end
    else if (ce)
    begin
      sampleValid <= running;
      if (running)
      begin
        sampleI <= iqMem[iqBank][rdAddr][31:16];
        sampleQ <= iqMem[iqBank][rdAddr][15:0];
        // bit n lights marker n+1; 0f lights all, 00 none
        markerOut <= mkrMem[mkrBank][rdAddr];
      end
      else
      begin
        sampleI <= `AWP_HALF_RST;
        sampleQ <= `AWP_HALF_RST;
        markerOut <= `AWP_MKR_OFF;
      end
    end
  end

endmodule

`default_nettype wire

// File: verilog/awp_params.svh
`ifndef AWP_PARAMS_SVH
`define AWP_PARAMS_SVH

// waveform store depth in points and its address width
`define AWP_DEPTH 1024
`define AWP_AW 10
// point counters reach DEPTH, so one bit wider than the address
`define AWP_CW 11
`define AWP_CNT_ONE 11'h001
`define AWP_CNT_ZERO 11'h000
`define AWP_DEPTH_CNT 11'h400
// least number of samples that makes a playable waveform
`define AWP_MIN_SAMPLES 11'h03C
// download kinds
`define AWP_KIND_IQ 1'b0
`define AWP_KIND_MKR 1'b1
// marker enables sit in the low nibble of a marker byte
`define AWP_MKR_MSB 3
`define AWP_MKR_LSB 0
`define AWP_MKR_OFF 4'h0
// byte positions inside one I/Q point, I high byte first
`define AWP_BYTE_LAST 2'h3
`define AWP_BYTE_FIRST 2'h0
`define AWP_BYTE_STEP 2'h1
// header settings word
`define AWP_HDR_W 32
`define AWP_HDR_RST 32'h00000000
`define AWP_IQ_RST 32'h00000000
`define AWP_HALF_RST 16'h0000
`define AWP_ADDR_ZERO 10'h000
`define AWP_ADDR_ONE 10'h001

`endif

// File: verilog/awp_pkg.sv
package awp_pkg;

  typedef enum logic [2:0] {
    AWP_ST_IDLE = 3'h1,
    AWP_ST_HDR = 3'h2,
    AWP_ST_PLAY = 3'h4
  } awp_state_t;

endpackage

// File: verification/awp_player_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "awp_params.svh"
module awp_player_asserts
  import awp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic dlStart,
  input wire logic dlEnd,
  input wire logic storeReq,
  input wire logic selectReq,
  input wire logic stopReq,
  input wire logic arbOn,
  input wire logic dlBusy,
  input wire logic dlError,
  input wire logic playable,
  input wire logic [`AWP_CW-1:0] waveLen,
  input wire logic playing,
  input wire logic sampleValid,
  input wire logic signed [15:0] sampleI,
  input wire logic signed [15:0] sampleQ,
  input wire logic [3:0] markerOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_sel;
    ce && selectReq && !stopReq;
  endsequence
  sequence s_go;
    s_sel ##2 (ce && arbOn && playable);
  endsequence
  a_idle_zero: assert property (!sampleValid |-> markerOut == 4'h0 && sampleI == 16'h0000 && sampleQ == 16'h0000)
    else $error("idle outputs not zero");
  a_off_silent: assert property (ce && !arbOn |=> !sampleValid)
    else $error("sample while disabled");
  a_valid_playing: assert property (sampleValid |-> $past(playing))
    else $error("sample outside play");
  a_len_playable: assert property (playable == (waveLen >= `AWP_MIN_SAMPLES))
    else $error("playable disagrees with length");
  a_start_busy: assert property (ce && dlStart |=> dlBusy)
    else $error("file not open");
  a_end_idle: assert property (ce && dlEnd && dlBusy |=> !dlBusy)
    else $error("file not closed");
  a_store_busy: assert property (ce && storeReq && dlBusy |=> dlError)
    else $error("store during load not refused");
  a_select_play: assert property (s_sel |-> ##2 playing)
    else $error("select did not reach play");
  a_first_sample: assert property (s_go |=> sampleValid)
    else $error("no first sample");
  a_stop_idle: assert property (ce && stopReq && playing |=> !playing)
    else $error("stop ignored");
endmodule
bind awp_player awp_player_asserts i_awp_player_asserts (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .dlStart(dlStart), .dlEnd(dlEnd), .storeReq(storeReq), .selectReq(selectReq), .stopReq(stopReq),
  .arbOn(arbOn), .dlBusy(dlBusy), .dlError(dlError), .playable(playable), .waveLen(waveLen),
  .playing(playing), .sampleValid(sampleValid), .sampleI(sampleI), .sampleQ(sampleQ), .markerOut(markerOut));
`default_nettype wire

// File: verification/awp_sink.sv
`timescale 1ns/1ps
`default_nettype none
module awp_sink
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sampleValid,
  output logic [31:0] cnt
);
  // modulator side takes one point per valid cycle, never stalls
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cnt <= 32'h00000000;
    else if (sampleValid)
      cnt <= cnt + 32'h00000001;
endmodule
`default_nettype wire

// File: verification/awp_player_test.sv
`timescale 1ns/1ps
`default_nettype none
module awp_player_test
  import awp_pkg::*;
;
  localparam logic [31:0] HDR = 32'h5A3C0F96;
  logic sys_clk, rst, dlStart, dlKind, dlValid, dlEnd, hdrLoad, storeReq, selectReq, stopReq, arbOn;
  logic [7:0] dlByte;
  logic dlBusy, dlError, pending, playable, playSettingsValid, playing, sampleValid;
  logic [10:0] waveLen;
  logic [31:0] playSettings, cnt;
  logic signed [15:0] sampleI, sampleQ;
  logic [3:0] markerOut;
  logic [7:0] mk [4] = '{8'h0F, 8'h05, 8'h00, 8'hF3};
  int nErrors = 0;
  int samplesChecked = 0;
  awp_player i_awp_player (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .dlStart(dlStart), .dlKind(dlKind),
    .dlValid(dlValid), .dlByte(dlByte), .dlEnd(dlEnd), .hdrLoad(hdrLoad), .hdrWord(HDR),
    .storeReq(storeReq), .selectReq(selectReq), .stopReq(stopReq), .arbOn(arbOn), .dlBusy(dlBusy),
    .dlError(dlError), .pending(pending), .playable(playable), .waveLen(waveLen),
    .playSettings(playSettings), .playSettingsValid(playSettingsValid), .playing(playing),
    .sampleValid(sampleValid), .sampleI(sampleI), .sampleQ(sampleQ), .markerOut(markerOut));
  awp_sink i_awp_sink (.sys_clk(sys_clk), .rst(rst), .sampleValid(sampleValid), .cnt(cnt));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // byte order: I high, I low, Q high, Q low; marker files one byte a point
  task dl(input logic kind, input int n, input logic [15:0] base, input int sh, input logic stMid);
    logic [15:0] w;
    dlStart <= 1'b1;
    dlKind <= kind;
    tick;
    dlStart <= 1'b0;
    for (int b = 0; b < (kind ? n : 4 * n); b++)
    begin
      w = (b % 4 < 2) ? base + 16'(b / 4) : ~(base + 16'(b / 4));
      dlValid <= 1'b1;
      dlByte <= kind ? mk[(b + sh) % 4] : (b % 2 ? w[7:0] : w[15:8]);
      storeReq <= stMid && b == 8;
      tick;
    end
    dlValid <= 1'b0;
    storeReq <= 1'b0;
    dlEnd <= 1'b1;
    tick;
    dlEnd <= 1'b0;
    tick;
  endtask
  task store;
    storeReq <= 1'b1;
    tick;
    storeReq <= 1'b0;
    tick;
    tick;
  endtask
  task play(input int n, input logic [15:0] base, input int sh, input logic mkOn);
    int w;
    logic [31:0] c0;
    selectReq <= 1'b1;
    tick;
    selectReq <= 1'b0;
    w = 0;
    while (sampleValid !== 1'b1 && w < 10)
    begin
      tick;
      w++;
    end
    chk(playSettingsValid, mkOn);
    chk(playSettings, HDR);
    // two extra points prove the wrap has no gap
    for (int k = 0; k < n + 2; k++)
    begin
      chk({16'h0000, sampleI}, base + 16'(k % n));
      chk({16'h0000, sampleQ}, 16'(~(base + 16'(k % n))));
      chk(markerOut, mkOn ? 4'(mk[(k % n + sh) % 4]) : 4'h0);
      tick;
    end
    arbOn <= 1'b0;
    tick;
    c0 = cnt;
    tick;
    tick;
    chk(cnt, c0);
    stopReq <= 1'b1;
    tick;
    stopReq <= 1'b0;
    arbOn <= 1'b1;
  endtask
  task t_full;
    dl(1'b0, 60, 16'h0100, 0, 1'b0);
    hdrLoad <= 1'b1;
    tick;
    hdrLoad <= 1'b0;
    dl(1'b1, 60, 16'h0000, 0, 1'b0);
    store;
    chk(waveLen, 32'd60);
    play(60, 16'h0100, 0, 1'b1);
  endtask
  task t_mkonly;
    dl(1'b1, 60, 16'h0000, 1, 1'b0);
    store;
    play(60, 16'h0100, 1, 1'b1);
  endtask
  task t_iqonly;
    dl(1'b0, 64, 16'h0200, 0, 1'b0);
    store;
    chk(playable, 1'b1);
    play(64, 16'h0200, 0, 1'b0);
  endtask
  task t_short;
    dl(1'b0, 59, 16'h0300, 0, 1'b1);
    chk(dlError, 1'b1);
    chk(pending, 1'b1);
    store;
    chk(pending, 1'b0);
    chk(playable, 1'b0);
    chk(waveLen, 32'd0);
  endtask
  initial
  begin
    {rst, dlStart, dlKind, dlValid, dlEnd, hdrLoad, storeReq, selectReq, stopReq} = 9'h100;
    arbOn = 1'b1;
    dlByte = 8'h00;
    repeat (16) tick;
    rst <= 1'b0;
    tick;
    t_full;
    t_mkonly;
    t_iqonly;
    t_short;
    results;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    nErrors++;
    results;
  end
endmodule
`default_nettype wire
